// [tpf_defs.svh]
`ifndef TPF_DEFS_SVH
`define TPF_DEFS_SVH
// Pointer width and depth of each FIFO
`define TPF_AW 11
`define TPF_DEPTH 12'h800
// Default offsets picked by preset codes 0..4
`define TPF_OFS_D0 11'h008
`define TPF_OFS_D1 11'h010
`define TPF_OFS_D2 11'h040
`define TPF_OFS_D3 11'h100
`define TPF_OFS_D4 11'h400
// Preset code for serial loading, and the last default preset code
`define TPF_PRE_SER 3'h5
`define TPF_PRE_LAST_DEF 3'h4
// Parity bit position on port A during parallel loading
`define TPF_PAR_BIT 8
// Serial loading ends at this bit index, parallel at this word index
`define TPF_SER_LAST 6'h2b
`define TPF_PAR_LAST 2'h3
`endif

// [tpf_pkg.sv]
`include "tpf_defs.svh"
package tpf_pkg;
  // Offset loading method, caught at FIFO1 master reset
  typedef enum logic [2:0] {
    TPF_M_DEF = 3'b001,
    TPF_M_SER = 3'b010,
    TPF_M_PAR = 3'b100
  } tpf_meth_t;

  // State of one FIFO with its mailbox and flag pipes
  typedef struct packed {
    logic [`TPF_AW-1:0] wr;
    logic [`TPF_AW-1:0] rd;
    logic [`TPF_AW:0]   cnt;
    logic [35:0]        out;
    logic [35:0]        asm;
    logic               ov;
    logic [1:0]         pc;
    logic               fall_through_timing;
    logic               big;
    logic               mrs_d;
    logic [`TPF_AW-1:0] ofs_e;
    logic [`TPF_AW-1:0] ofs_f;
    logic [1:0]         sf;
    logic [1:0]         saf;
    logic [1:0]         se;
    logic [1:0]         sae;
    logic               mail_n;
    logic [17:0]        mail;
  } tpf_fifo_t;

  // Whole block state
  typedef struct packed {
    tpf_fifo_t              f1;
    tpf_fifo_t              f2;
    tpf_meth_t              meth;
    logic                   prog_done;
    logic                   par;
    logic [1:0]             pidx;
    logic [4*`TPF_AW-1:0]   sh;
    logic [5:0]             nbit;
    logic [35:0]            a_dout;
    logic                   a_oe;
    logic [17:0]            b_dout;
  } tpf_state_t;
endpackage

// [tpf_core.sv]
// Functional notes
// - Two FIFOs: port A to port B, and port C back to port A.
// - Ports B and C move 18-bit words or 9-bit bytes, big or little endian.
// - Transfers happen only on a port clock edge; port reads and writes also need their enables, loopback and fall-through loads do not.
// - Port clocks independent; same-edge write and read both handled.
// - Two mailboxes bypass the FIFOs, each with an active-low new-mail flag.
// - Master reset clears pointers; FIFO1 master reset also latches the offset loading method.
// - Partial reset clears pointers but keeps method and offsets.
// - Retransmit rewinds only the read pointer; data and write pointer stay.
// - Retransmit is replay mode plus the shared partial reset strobe.
// - Standard timing: first word waits in memory until a read.
// - Fall-through timing: first word appears unread; later words need reads.
// - Select pin at master reset release picks standard or fall-through.
// - Standard timing: flags show empty on read side, full on write side.
// - Fall-through timing: flags show space available and output valid.
// - Each FIFO has almost-empty and almost-full flags against offsets.
// - Write-side flags two-stage on writer clock, read-side on reader clock.
// - Offsets load in parallel via port A or serially, per method.
// - Preset pins pick serial, parallel or default 8/16/64/256/1024.
// - With interspersed parity, A8 is skipped in parallel offset loading.
// - Loopback writes FIFO2 output into FIFO1; port A driven only if reading.
// - Loop writes FIFO1 only while it has room but pops FIFO2 even when FIFO1 is full; empty source repeats its last word.
// - Select pin high at master reset means big endian, low little.
// - Almost flags go low when count or free space is at or below offset.
`timescale 1ns/1ps
`include "tpf_defs.svh"
module tpf_core (
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  input  wire logic        i_port_a_clock_en,
  input  wire logic        i_port_b_clock_en,
  input  wire logic        i_port_c_clock_en,
  input  wire logic        i_master_reset_fifo1_n,
  input  wire logic        i_master_reset_fifo2_n,
  input  wire logic        i_flush_reset_fifo1_n,
  input  wire logic        i_flush_reset_fifo2_n,
  input  wire logic        i_replay_mode,
  input  wire logic        i_byte_order_timing_select,
  input  wire logic        i_offset_preset_sel0,
  input  wire logic        i_offset_preset_sel1,
  input  wire logic        i_offset_preset_sel2,
  input  wire logic        i_serial_offset_input,
  input  wire logic        i_serial_offset_en,
  input  wire logic        i_parity_interspersed,
  input  wire logic        i_loop_n,
  input  wire logic        i_port_a_direction,
  input  wire logic        i_a_en,
  input  wire logic        i_a_mail_sel,
  input  wire logic [35:0] i_a_data,
  input  wire logic        i_b_en,
  input  wire logic        i_b_mail_sel,
  input  wire logic        i_b_byte_mode,
  input  wire logic        i_c_en,
  input  wire logic        i_c_mail_sel,
  input  wire logic        i_c_byte_mode,
  input  wire logic [17:0] i_c_data,
  output logic      [35:0] o_a_data,
  output logic             o_a_data_oe,
  output logic      [17:0] o_b_data,
  output logic             o_port_a_full_space_flag,
  output logic             o_port_c_full_space_flag,
  output logic             o_port_a_empty_valid_flag,
  output logic             o_port_b_empty_valid_flag,
  output logic             o_near_empty_port_a_n,
  output logic             o_near_empty_port_b_n,
  output logic             o_near_full_port_a_n,
  output logic             o_near_full_port_c_n,
  output logic             o_mail_one_full_n,
  output logic             o_mail_two_full_n
);
  tpf_pkg::tpf_state_t st_reg;
  tpf_pkg::tpf_state_t st_next;
  logic [35:0]         mem1 [0:(1<<`TPF_AW)-1];
  logic [35:0]         mem2 [0:(1<<`TPF_AW)-1];
  logic [35:0]         rw1;
  logic [35:0]         rw2;
  logic [35:0]         wd1;
  logic [35:0]         wd2;
  logic [35:0]         lw;
  logic                push1;
  logic                push2;
  logic                pop1;
  logic                pop2;
  logic [`TPF_AW-1:0]  ofs_in;
  logic [2:0]          sel;
  logic                a_wr;
  logic                a_rd;
  logic                b_rd;
  logic                c_wr;
  logic                loop;
  logic [3:0]          rf1;
  logic [3:0]          rf2;

  // Piece of a 36-bit word for an 18-bit or 9-bit port
  function automatic logic [17:0] get_piece(input logic [35:0] w, input logic [1:0] i,
                                            input logic byt, input logic big);
    logic [1:0] k;
    k = big ? ((byt ? 2'h3 : 2'h1) - i) : i;
    get_piece = byt ? {9'h000, w[9*k +: 9]} : w[18*k[0] +: 18];
  endfunction

  // Place one port piece into a 36-bit word under assembly
  function automatic logic [35:0] put_piece(input logic [35:0] w, input logic [17:0] p,
                                            input logic [1:0] i, input logic byt,
                                            input logic big);
    logic [1:0]  k;
    logic [35:0] r;
    r = w;
    k = big ? ((byt ? 2'h3 : 2'h1) - i) : i;
    if (byt) begin
      r[9*k +: 9] = p[8:0];
    end else begin
      r[18*k[0] +: 18] = p;
    end
    put_piece = r;
  endfunction

  // True on the last piece of a word
  function automatic logic last_piece(input logic [1:0] i, input logic byt);
    last_piece = (i == (byt ? 2'h3 : 2'h1));
  endfunction

  // Default offset for preset codes 0..4
  function automatic logic [`TPF_AW-1:0] ofs_default(input logic [2:0] s);
    case (s)
      3'h0:    ofs_default = `TPF_OFS_D0;
      3'h1:    ofs_default = `TPF_OFS_D1;
      3'h2:    ofs_default = `TPF_OFS_D2;
      3'h3:    ofs_default = `TPF_OFS_D3;
      default: ofs_default = `TPF_OFS_D4;
    endcase
  endfunction

  // Raw flags: space, not near full, valid, not near empty
  function automatic logic [3:0] raw_flags(input tpf_pkg::tpf_fifo_t f);
    logic [`TPF_AW:0] free;
    free = `TPF_DEPTH - f.cnt;
    raw_flags[3] = f.cnt < `TPF_DEPTH;
    raw_flags[2] = free > {1'b0, f.ofs_f};
    raw_flags[1] = f.fall_through_timing ? f.ov : (f.cnt != '0);
    raw_flags[0] = f.cnt > {1'b0, f.ofs_e};
  endfunction

  // Resets of one FIFO; flush and replay share the strobe
  function automatic tpf_pkg::tpf_fifo_t fifo_reset(input tpf_pkg::tpf_fifo_t f,
                                                    input logic mrs_n, input logic prs_n,
                                                    input logic replay_mode, input logic pin,
                                                    input logic [2:0] s);
    tpf_pkg::tpf_fifo_t r;
    r = f;
    if (!mrs_n) begin
      r.wr = '0;
      r.rd = '0;
      r.cnt = '0;
      r.ov = 1'b0;
      r.pc = 2'h0;
      r.mail_n = 1'b1;
      r.mrs_d = 1'b1;
      r.big = pin;
      if (s <= `TPF_PRE_LAST_DEF) begin
        r.ofs_e = ofs_default(s);
        r.ofs_f = ofs_default(s);
      end
    end else begin
      if (f.mrs_d) begin
        r.fall_through_timing = !pin;
        r.mrs_d = 1'b0;
      end
      if (!prs_n) begin
        r.ov = 1'b0;
        r.pc = 2'h0;
        r.rd = '0;
        // replay mode turns the strobe into retransmit
        if (replay_mode) begin
          r.cnt = f.cnt + {1'b0, f.rd};
        end else begin
          r.wr = '0;
          r.cnt = '0;
        end
      end
    end
    fifo_reset = r;
  endfunction

  // Qualified port events; each port has its own clock enable
  // edge plus enables
  assign a_wr = i_port_a_clock_en && i_a_en && i_port_a_direction;
  assign a_rd = i_port_a_clock_en && i_a_en && !i_port_a_direction;
  assign b_rd = i_port_b_clock_en && i_b_en;
  assign c_wr = i_port_c_clock_en && i_c_en;
  assign loop = !i_loop_n;
  assign sel = {i_offset_preset_sel2, i_offset_preset_sel1, i_offset_preset_sel0};
  assign rw1 = mem1[st_reg.f1.rd];
  assign rw2 = mem2[st_reg.f2.rd];
  // A8 skipped when parity is interspersed
  assign ofs_in = st_reg.par ? {i_a_data[`TPF_AW:`TPF_PAR_BIT+1], i_a_data[`TPF_PAR_BIT-1:0]}
                             : i_a_data[`TPF_AW-1:0];

  // Next state of the whole block
  always_comb begin
    st_next = st_reg;
    push1 = 1'b0;
    push2 = 1'b0;
    pop1 = 1'b0;
    pop2 = 1'b0;
    wd1 = '0;
    wd2 = '0;
    lw = '0;
    // reads clear first so a same-cycle store wins
    if (b_rd && i_b_mail_sel) begin
      st_next.b_dout = st_reg.f1.mail;
      st_next.f1.mail_n = 1'b1;
    end
    if (a_rd && i_a_mail_sel) begin
      st_next.a_dout = {18'h00000, st_reg.f2.mail};
      st_next.f2.mail_n = 1'b1;
    end
    // mailbox stores sized to the port width
    if (a_wr && i_a_mail_sel) begin
      st_next.f1.mail = i_b_byte_mode ? {9'h000, i_a_data[8:0]} : i_a_data[17:0];
      st_next.f1.mail_n = 1'b0;
    end
    if (c_wr && i_c_mail_sel) begin
      st_next.f2.mail = i_c_byte_mode ? {9'h000, i_c_data[8:0]} : i_c_data;
      st_next.f2.mail_n = 1'b0;
    end
    // parallel offsets take the first port A writes
    if (a_wr && !i_a_mail_sel && !loop) begin
      if (!st_reg.prog_done) begin
        if (st_reg.meth == tpf_pkg::TPF_M_PAR) begin
          case (st_reg.pidx)
            2'h0:    st_next.f1.ofs_e = ofs_in;
            2'h1:    st_next.f1.ofs_f = ofs_in;
            2'h2:    st_next.f2.ofs_e = ofs_in;
            default: st_next.f2.ofs_f = ofs_in;
          endcase
          st_next.pidx = st_reg.pidx + 2'h1;
          st_next.prog_done = (st_reg.pidx == `TPF_PAR_LAST);
        end
      end else if (st_reg.f1.cnt < `TPF_DEPTH) begin
        push1 = 1'b1;
        wd1 = i_a_data;
      end
    end
    // Serial offsets shift in on port A edges, writes held off till done
    if (i_port_a_clock_en && i_serial_offset_en && !st_reg.prog_done &&
        st_reg.meth == tpf_pkg::TPF_M_SER) begin
      st_next.sh = {st_reg.sh[4*`TPF_AW-2:0], i_serial_offset_input};
      st_next.nbit = st_reg.nbit + 6'h01;
      if (st_reg.nbit == `TPF_SER_LAST) begin
        st_next.prog_done = 1'b1;
        {st_next.f1.ofs_e, st_next.f1.ofs_f, st_next.f2.ofs_e, st_next.f2.ofs_f} = st_next.sh;
      end
    end
    // loop feeds FIFO2 output into FIFO1
    if (loop && i_port_a_clock_en) begin
      // empty source repeats its last word
      lw = (st_reg.f2.cnt != '0) ? rw2 : st_reg.f2.out;
      pop2 = (st_reg.f2.cnt != '0);
      st_next.f2.out = lw;
      if (st_reg.f1.cnt < `TPF_DEPTH && st_reg.prog_done) begin
        push1 = 1'b1;
        wd1 = lw;
      end
      if (!i_port_a_direction) begin
        st_next.a_dout = lw;
      end
    end
    // Port A reads FIFO2
    if (a_rd && !i_a_mail_sel && !loop) begin
      if (st_reg.f2.fall_through_timing) begin
        st_next.f2.ov = 1'b0;
      end else if (st_reg.f2.cnt != '0) begin
        pop2 = 1'b1;
        st_next.f2.out = rw2;
        st_next.a_dout = rw2;
      end
    end
    if (i_port_a_clock_en && !loop && st_reg.f2.fall_through_timing && !st_next.f2.ov &&
        st_reg.f2.cnt != '0) begin
      pop2 = 1'b1;
      st_next.f2.out = rw2;
      st_next.f2.ov = 1'b1;
      st_next.a_dout = rw2;
    end
    // port B reads pieces of FIFO1 words
    if (b_rd && !i_b_mail_sel) begin
      if (st_reg.f1.pc != 2'h0 || (st_reg.f1.fall_through_timing && st_reg.f1.ov)) begin
        st_next.b_dout = get_piece(st_reg.f1.out, st_reg.f1.pc, i_b_byte_mode, st_reg.f1.big);
        st_next.f1.pc = st_reg.f1.pc + 2'h1;
        if (last_piece(st_reg.f1.pc, i_b_byte_mode)) begin
          st_next.f1.pc = 2'h0;
          st_next.f1.ov = 1'b0;
        end
      end else if (!st_reg.f1.fall_through_timing && st_reg.f1.cnt != '0) begin
        pop1 = 1'b1;
        st_next.f1.out = rw1;
        st_next.f1.pc = 2'h1;
        st_next.b_dout = get_piece(rw1, 2'h0, i_b_byte_mode, st_reg.f1.big);
      end
    end
    if (i_port_b_clock_en && st_reg.f1.fall_through_timing && !st_next.f1.ov && st_reg.f1.cnt != '0) begin
      pop1 = 1'b1;
      st_next.f1.out = rw1;
      st_next.f1.ov = 1'b1;
      st_next.f1.pc = 2'h0;
      st_next.b_dout = get_piece(rw1, 2'h0, i_b_byte_mode, st_reg.f1.big);
    end
    // port C pieces assemble into FIFO2 words
    if (c_wr && !i_c_mail_sel) begin
      st_next.f2.asm = put_piece(st_reg.f2.asm, i_c_data, st_reg.f2.pc, i_c_byte_mode,
                                 st_reg.f2.big);
      st_next.f2.pc = st_reg.f2.pc + 2'h1;
      if (last_piece(st_reg.f2.pc, i_c_byte_mode)) begin
        st_next.f2.pc = 2'h0;
        if (st_reg.f2.cnt < `TPF_DEPTH) begin
          push2 = 1'b1;
          wd2 = st_next.f2.asm;
        end
      end
    end
    // push and pop in one cycle net out
    st_next.f1.cnt = st_reg.f1.cnt + {{`TPF_AW{1'b0}}, push1} - {{`TPF_AW{1'b0}}, pop1};
    st_next.f2.cnt = st_reg.f2.cnt + {{`TPF_AW{1'b0}}, push2} - {{`TPF_AW{1'b0}}, pop2};
    st_next.f1.wr = st_reg.f1.wr + {{(`TPF_AW-1){1'b0}}, push1};
    st_next.f2.wr = st_reg.f2.wr + {{(`TPF_AW-1){1'b0}}, push2};
    st_next.f1.rd = st_reg.f1.rd + {{(`TPF_AW-1){1'b0}}, pop1};
    st_next.f2.rd = st_reg.f2.rd + {{(`TPF_AW-1){1'b0}}, pop2};
    // each FIFO resets on its own pins
    st_next.f1 = fifo_reset(st_next.f1, i_master_reset_fifo1_n, i_flush_reset_fifo1_n,
                            i_replay_mode, i_byte_order_timing_select, sel);
    st_next.f2 = fifo_reset(st_next.f2, i_master_reset_fifo2_n, i_flush_reset_fifo2_n,
                            i_replay_mode, i_byte_order_timing_select, sel);
    if (!i_master_reset_fifo1_n) begin
      // loading method caught with FIFO1 master reset
      st_next.par = i_parity_interspersed;
      st_next.pidx = 2'h0;
      st_next.nbit = 6'h00;
      st_next.prog_done = (sel <= `TPF_PRE_LAST_DEF);
      case (sel)
        3'h0, 3'h1, 3'h2, 3'h3, 3'h4: st_next.meth = tpf_pkg::TPF_M_DEF;
        `TPF_PRE_SER:                 st_next.meth = tpf_pkg::TPF_M_SER;
        default:                      st_next.meth = tpf_pkg::TPF_M_PAR;
      endcase
    end
    // Raw flags taken once, after pointers and resets have settled
    rf1 = raw_flags(st_next.f1);
    rf2 = raw_flags(st_next.f2);
    // two stages on port A clock for FIFO1 write-side and FIFO2 read-side flags
    if (i_port_a_clock_en) begin
      st_next.f1.sf = {st_reg.f1.sf[0], rf1[3]};
      st_next.f1.saf = {st_reg.f1.saf[0], rf1[2]};
      st_next.f2.se = {st_reg.f2.se[0], rf2[1]};
      st_next.f2.sae = {st_reg.f2.sae[0], rf2[0]};
    end
    // FIFO1 read-side flags on port B clock, FIFO2 write-side flags on port C clock
    if (i_port_b_clock_en) begin
      st_next.f1.se = {st_reg.f1.se[0], rf1[1]};
      st_next.f1.sae = {st_reg.f1.sae[0], rf1[0]};
    end
    if (i_port_c_clock_en) begin
      st_next.f2.sf = {st_reg.f2.sf[0], rf2[3]};
      st_next.f2.saf = {st_reg.f2.saf[0], rf2[2]};
    end
    // port A driven only while set for reading
    st_next.a_oe = !i_port_a_direction;
    if (!i_rst_n) begin
      st_next = '0;
      st_next.f1.mail_n = 1'b1;
      st_next.f2.mail_n = 1'b1;
      st_next.f1.ofs_e = `TPF_OFS_D0;
      st_next.f1.ofs_f = `TPF_OFS_D0;
      st_next.f2.ofs_e = `TPF_OFS_D0;
      st_next.f2.ofs_f = `TPF_OFS_D0;
      st_next.meth = tpf_pkg::TPF_M_DEF;
      st_next.prog_done = 1'b1;
    end
  end

  // State register
  always_ff @(posedge i_mclk) begin
    st_reg <= st_next;
  end

  // Memories; a push during a master or partial reset of its FIFO is dropped
  always_ff @(posedge i_mclk) begin
    if (push1 && i_master_reset_fifo1_n && i_flush_reset_fifo1_n) begin
      mem1[st_reg.f1.wr] <= wd1;
    end
    if (push2 && i_master_reset_fifo2_n && i_flush_reset_fifo2_n) begin
      mem2[st_reg.f2.wr] <= wd2;
    end
  end

  // Outputs straight from the state register
  assign o_a_data = st_reg.a_dout;
  assign o_a_data_oe = st_reg.a_oe;
  assign o_b_data = st_reg.b_dout;
  assign o_port_a_full_space_flag = st_reg.f1.sf[1];
  assign o_port_c_full_space_flag = st_reg.f2.sf[1];
  assign o_port_a_empty_valid_flag = st_reg.f2.se[1];
  assign o_port_b_empty_valid_flag = st_reg.f1.se[1];
  assign o_near_empty_port_a_n = st_reg.f2.sae[1];
  assign o_near_empty_port_b_n = st_reg.f1.sae[1];
  assign o_near_full_port_a_n = st_reg.f1.saf[1];
  assign o_near_full_port_c_n = st_reg.f2.saf[1];
  assign o_mail_one_full_n = st_reg.f1.mail_n;
  assign o_mail_two_full_n = st_reg.f2.mail_n;

  // Checks on the block's own behaviour
  chk_mail_store:
    assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (a_wr && i_a_mail_sel && i_master_reset_fifo1_n) |=> !o_mail_one_full_n)
    else $error("mailbox one flag not set after store");
  chk_mail_clear:
    assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (b_rd && i_b_mail_sel && !(a_wr && i_a_mail_sel)) |=> o_mail_one_full_n)
    else $error("mailbox one flag not cleared by read");
  chk_master_reset:
    assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      !i_master_reset_fifo1_n |=> (st_reg.f1.cnt == '0 && st_reg.f1.wr == '0))
    else $error("master reset left FIFO1 pointers");
  chk_flush_reset:
    assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (i_master_reset_fifo2_n && !i_flush_reset_fifo2_n && !i_replay_mode)
      |=> (st_reg.f2.cnt == '0 && st_reg.f2.rd == '0 && $stable(st_reg.f2.ofs_e)))
    else $error("flush reset wrong on FIFO2");
  chk_replay_rewind:
    assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (i_master_reset_fifo1_n && !i_flush_reset_fifo1_n && i_replay_mode && !push1)
      |=> (st_reg.f1.rd == '0 && st_reg.f1.wr == $past(st_reg.f1.wr)))
    else $error("retransmit touched more than read pointer");
  chk_fall_through:
    assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (i_port_b_clock_en && st_reg.f1.fall_through_timing && !st_reg.f1.ov && st_reg.f1.cnt != '0 &&
       i_master_reset_fifo1_n && i_flush_reset_fifo1_n) |=> st_reg.f1.ov)
    else $error("first word did not fall through");
  chk_flag_edge:
    assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      ($past(i_rst_n) && $changed(o_port_a_full_space_flag)) |-> $past(i_port_a_clock_en))
    else $error("port A full flag moved off its clock");
  chk_b_data_edge:
    assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      ($past(i_rst_n) && $changed(o_b_data)) |-> $past(i_port_b_clock_en))
    else $error("port B data moved off its clock");
  chk_loop_feed:
    assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (loop && i_port_a_clock_en && st_reg.prog_done && st_reg.f1.cnt < `TPF_DEPTH &&
       !pop1 && i_master_reset_fifo1_n && i_flush_reset_fifo1_n)
      |=> st_reg.f1.cnt == $past(st_reg.f1.cnt) + 1)
    else $error("loopback did not feed FIFO1");
endmodule

// [tpf_port_peer.sv]
`timescale 1ns/1ps
module tpf_port_peer (
  input  wire logic i_mclk,
  input  wire logic i_b_stop,
  output logic      o_a_tick,
  output logic      o_b_tick,
  output logic      o_c_tick
);
  // Port clocks coincide with the system clock, the hardest case for same-edge traffic;
  // port B can be held off to show that nothing moves without its edge
  // coincident port clocks
  always @(negedge i_mclk) begin
    o_a_tick <= 1'b1;
    o_b_tick <= !i_b_stop;
    o_c_tick <= 1'b1;
  end
  // Ticks known from time zero
  initial {o_a_tick, o_b_tick, o_c_tick} = 3'h7;
endmodule

// [triple_port_dual_fifo_bus_matching_bench.sv]
`timescale 1ns/1ps
module triple_port_dual_fifo_bus_matching_bench;
  logic        i_mclk = 1'b0, i_rst_n, i_port_a_clock_en, i_port_b_clock_en, i_port_c_clock_en;
  logic        i_master_reset_fifo1_n, i_master_reset_fifo2_n, i_flush_reset_fifo1_n;
  logic        i_flush_reset_fifo2_n, i_replay_mode, i_byte_order_timing_select, i_loop_n;
  logic        i_offset_preset_sel0, i_offset_preset_sel1, i_offset_preset_sel2;
  logic        i_serial_offset_input, i_serial_offset_en, i_parity_interspersed;
  logic        i_port_a_direction, i_a_en, i_a_mail_sel, i_b_en, i_b_mail_sel, i_b_byte_mode;
  logic        i_c_en, i_c_mail_sel, i_c_byte_mode, o_a_data_oe, o_mail_one_full_n;
  logic [35:0] i_a_data, o_a_data;
  logic [17:0] i_c_data, o_b_data;
  logic        o_port_a_empty_valid_flag, o_port_b_empty_valid_flag, o_near_empty_port_b_n;
  int          num_errors = 0, cmp_count = 0;
  logic        b_stop = 1'b0, o_mail_two_full_n;
  tpf_port_peer peer_u (.i_mclk, .o_a_tick(i_port_a_clock_en), .o_b_tick(i_port_b_clock_en),
    .o_c_tick(i_port_c_clock_en), .i_b_stop(b_stop));
  tpf_core dut_u (.i_mclk, .i_rst_n, .i_port_a_clock_en, .i_port_b_clock_en, .i_port_c_clock_en,
    .i_master_reset_fifo1_n, .i_master_reset_fifo2_n, .i_flush_reset_fifo1_n,
    .i_flush_reset_fifo2_n, .i_replay_mode, .i_byte_order_timing_select, .i_offset_preset_sel0,
    .i_offset_preset_sel1, .i_offset_preset_sel2, .i_serial_offset_input, .i_serial_offset_en,
    .i_parity_interspersed, .i_loop_n, .i_port_a_direction, .i_a_en, .i_a_mail_sel, .i_a_data,
    .i_b_en, .i_b_mail_sel, .i_b_byte_mode, .i_c_en, .i_c_mail_sel, .i_c_byte_mode, .i_c_data,
    .o_a_data, .o_a_data_oe, .o_b_data, .o_port_a_full_space_flag(), .o_port_c_full_space_flag(),
    .o_port_a_empty_valid_flag, .o_port_b_empty_valid_flag, .o_near_empty_port_a_n(),
    .o_near_empty_port_b_n, .o_near_full_port_a_n(), .o_near_full_port_c_n(),
    .o_mail_one_full_n, .o_mail_two_full_n);
  // Free-running system clock
  always #10 i_mclk = ~i_mclk;
  task chk(input string n, input logic [35:0] s, input logic [35:0] e);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s exp %h got %h", n, e, s);
    end
  endtask
  task final_report;
    $display("Checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Port A write of one word; idle cycle after so enables never toggle twice at once
  task wr_a(input logic [35:0] w, input logic ms);
    {i_port_a_direction, i_a_en, i_a_mail_sel, i_a_data} = {2'h3, ms, w};
    @(negedge i_mclk);
    i_a_en = 1'b0;
    @(negedge i_mclk);
  endtask
  // Port B read of n pieces, each checked the cycle after it is taken
  task rd_b(input logic [35:0] w, input logic byt, input int n);
    {i_b_byte_mode, i_b_en} = {byt, 1'b1};
    for (int k = 0; k < n; k++) begin
      @(negedge i_mclk);
      chk("port b piece", byt ? o_b_data[8:0] : o_b_data, byt ? w[9*k+:9] : w[18*k+:18]);
    end
    i_b_en = 1'b0;
    @(negedge i_mclk);
  endtask
  task t_mail;
    wr_a(36'h91a2a5c3d, 1'b1);
    chk("mail one flag set", o_mail_one_full_n, 1'b0);
    i_b_mail_sel = 1'b1;
    rd_b(36'h91a2a5c3d, 1'b0, 1);
    i_b_mail_sel = 1'b0;
    chk("mail one flag clear", o_mail_one_full_n, 1'b1);
    {i_c_mail_sel, i_c_en, i_c_data} = {2'h3, 18'h2b3c4};
    @(negedge i_mclk);
    {i_c_en, i_port_a_direction, i_a_en, i_a_mail_sel} = 4'h3;
    chk("mail two flag set", o_mail_two_full_n, 1'b0);
    @(negedge i_mclk);
    {i_c_mail_sel, i_a_en, i_a_mail_sel} = 3'h0;
    chk("mail two data", o_a_data, 36'h2b3c4);
    chk("mail two flag clear", o_mail_two_full_n, 1'b1);
  endtask
  task t_fifo_ab;
    wr_a(36'h3cafe1234, 1'b0);
    wr_a(36'h876543210, 1'b0);
    repeat (4) @(negedge i_mclk);
    chk("b data held", o_b_data, 18'h25c3d);
    chk("b valid flag", o_port_b_empty_valid_flag, 1'b1);
    chk("b near empty", o_near_empty_port_b_n, 1'b0);
    rd_b(36'h3cafe1234, 1'b0, 2);
    rd_b(36'h876543210, 1'b0, 2);
    repeat (4) @(negedge i_mclk);
    chk("b empty flag", o_port_b_empty_valid_flag, 1'b0);
  endtask
  task t_replay;
    {i_replay_mode, i_flush_reset_fifo1_n} = 2'h2;
    @(negedge i_mclk);
    i_flush_reset_fifo1_n = 1'b1;
    @(negedge i_mclk);
    {i_replay_mode, b_stop} = 2'h1;
    @(negedge i_mclk);
    i_b_en = 1'b1;
    repeat (2) @(negedge i_mclk);
    chk("b held without clock", o_b_data, 36'h876543210 >> 18);
    {i_b_en, b_stop} = 2'h0;
    repeat (4) @(negedge i_mclk);
    rd_b(36'h3cafe1234, 1'b1, 4);
  endtask
  task t_flush;
    chk("b valid before flush", o_port_b_empty_valid_flag, 1'b1);
    // replay mode held low through the partial reset
    {i_replay_mode, i_flush_reset_fifo1_n, i_flush_reset_fifo2_n} = 3'h0;
    @(negedge i_mclk);
    {i_flush_reset_fifo1_n, i_flush_reset_fifo2_n} = 2'h3;
    repeat (4) @(negedge i_mclk);
    chk("b empty after flush", o_port_b_empty_valid_flag, 1'b0);
  endtask
  task t_fifo_ca;
    {i_c_byte_mode, i_c_en} = 2'h3;
    for (int k = 0; k < 4; k++) begin
      i_c_data = {9'h000, 9'(36'h5a5f0c3e1 >> (9 * k))};
      @(negedge i_mclk);
    end
    i_c_en = 1'b0;
    repeat (4) @(negedge i_mclk);
    chk("a valid flag", o_port_a_empty_valid_flag, 1'b1);
    {i_port_a_direction, i_a_en} = 2'h1;
    @(negedge i_mclk);
    i_a_en = 1'b0;
    chk("port a word", o_a_data, 36'h5a5f0c3e1);
    chk("port a drive", o_a_data_oe, 1'b1);
  endtask
  // Source is empty here, so one loop edge copies its last word into FIFO1
  task t_loop;
    i_loop_n = 1'b0;
    @(negedge i_mclk);
    i_loop_n = 1'b1;
    repeat (4) @(negedge i_mclk);
    rd_b(36'h5a5f0c3e1, 1'b0, 2);
  endtask
  // Second master reset of FIFO1 with the select pin low picks fall-through timing
  task t_fall_through;
    {i_master_reset_fifo1_n, i_byte_order_timing_select} = 2'h0;
    @(negedge i_mclk);
    i_master_reset_fifo1_n = 1'b1;
    repeat (4) @(negedge i_mclk);
    wr_a(36'h123456789, 1'b0);
    repeat (4) @(negedge i_mclk);
    chk("b fell through", o_b_data, 36'h123456789 & 36'h3ffff);
    chk("b output ready", o_port_b_empty_valid_flag, 1'b1);
    rd_b(36'h123456789, 1'b0, 2);
    repeat (4) @(negedge i_mclk);
    chk("b output drained", o_port_b_empty_valid_flag, 1'b0);
  endtask
  // Reset, little endian caught in master reset, standard timing after release
  initial begin
    {i_rst_n, i_master_reset_fifo1_n, i_master_reset_fifo2_n, i_replay_mode, i_a_en, i_b_en,
     i_c_en, i_a_mail_sel, i_b_mail_sel, i_c_mail_sel, i_b_byte_mode, i_c_byte_mode, i_a_data,
     i_c_data, i_byte_order_timing_select, i_offset_preset_sel0, i_offset_preset_sel1,
     i_offset_preset_sel2, i_serial_offset_input, i_serial_offset_en, i_parity_interspersed,
     i_port_a_direction} = '0;
    {i_flush_reset_fifo1_n, i_flush_reset_fifo2_n, i_loop_n} = 3'h7;
    repeat (4) @(negedge i_mclk);
    i_rst_n = 1'b1;
    repeat (2) @(negedge i_mclk);
    {i_byte_order_timing_select, i_master_reset_fifo1_n, i_master_reset_fifo2_n} = 3'h7;
    repeat (4) @(negedge i_mclk);
    t_mail();
    t_fifo_ab();
    t_replay();
    t_flush();
    t_fifo_ca();
    t_loop();
    t_fall_through();
    final_report();
  end
  // Run needs about 90 cycles; cut a hang well beyond that
  initial begin
    #20000;
    num_errors++;
    final_report();
  end
endmodule
